// File: hdl/nvrs_pkg.sv
/*
  Package for the three-resistor setting register bank: register
  addresses, reset values, bus address layout, timing and carrier types.
  Assumes a 125 MHz system clock sampling the two-wire bus pins.
*/
`default_nettype none
package nvrs_pkg;
  localparam logic [7:0] REG_ZERO_ADDR = 8'h00_f8;
  localparam logic [7:0] REG_ONE_ADDR  = 8'h00_f9;
  localparam logic [7:0] REG_TWO_ADDR  = 8'h00_fa;
  localparam logic [7:0] SETTING_RESET = 8'h00_7f;
  localparam int         HIZ_BIT       = 7;
  // Fixed upper bits of the device address; the value is arbitrary.
  localparam logic [3:0] DEV_ADDR_FIXED = 4'h0_5;
  localparam int         CLK_MHZ        = 125;
  localparam int         WRITE_TIME_MS  = 20;
  localparam int         WRITE_CYCLES   = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] BIT_LAST       = 4'h0_7;
  localparam logic [3:0] BIT_ACK        = 4'h0_8;
  localparam logic [3:0] BIT_END        = 4'h0_9;

  typedef struct packed {
    logic hiz;
    logic [6:0] position;
  } nvrs_setting_t;

  typedef enum logic [2:0] {
    NVRS_IDLE, NVRS_DEVADDR, NVRS_REGADDR, NVRS_DATA, NVRS_READ,
    NVRS_IGNORE
  } nvrs_state_t;
endpackage
`default_nettype wire

// File: hdl/nvrs_top.sv
/*
  Two-wire slave with three nonvolatile resistor setting registers and a
  timed commit cycle after the stop condition.
  Assumes the bus pins are asynchronous and the bus clock is far slower
  than mclk_i; the open-drain data line is resolved outside.
*/
// What this block does
// - Three 8-bit setting registers at F8h, F9h, FAh drive resistors 0..2.
// - Each setting register resets to factory value 7Fh.
// - Values 00h to 7Fh select one of 128 linear positions.
// - Written values above 7Fh set the MSB, putting the resistor high-Z.
// - Nonvolatile commit cycle starts only at the stop after the data.
// - Address-select pins are compared with the received device address.
// - Clock is input only; data line is only pulled low or released.
// - Address byte MSB first; acknowledge only when the pin bits match.
// - Write is address, register, data, each acknowledged, then stop.
// - Read: dummy write, repeated start, read address, one byte, NACK.
// - No byte is acknowledged while the commit cycle runs.
`default_nettype none
module nvrs_top #(
  parameter int WRITE_CYCLES = nvrs_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Two-wire bus
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe_o,
  // Address select pins
  input  wire logic              address_select_pin_0_i,
  input  wire logic              address_select_pin_1_i,
  input  wire logic              address_select_pin_2_i,
  // Resistor settings and commit busy flag
  output var  nvrs_pkg::nvrs_setting_t resistor_zero_terminal_o,
  output var  nvrs_pkg::nvrs_setting_t resistor_one_terminal_o,
  output var  nvrs_pkg::nvrs_setting_t resistor_two_terminal_o,
  output var  logic              nv_busy_o
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_d;
  logic       sda_d;
  nvrs_pkg::nvrs_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  reg_addr;
  logic [7:0]  data_byte;
  logic        is_read;
  logic [3:0]  slot;
  logic [2:0]  pins_s;
  logic [2:0]  pins;
  logic        ack_drive;
  logic        pend;
  logic [31:0] busy_cnt;
  logic [7:0]  setting [3];
  logic        busy;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pins_s <= 3'h0;
      pins  <= 3'h0;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      pins_s <= {address_select_pin_2_i, address_select_pin_1_i,
                 address_select_pin_0_i};
      pins  <= pins_s;
    end
  end

  wire scl      = scl_s[1];
  wire sda      = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire addr_match = (rx_byte[7:4] == nvrs_pkg::DEV_ADDR_FIXED) &&
                    (rx_byte[3:1] == pins);
  wire byte_done = scl_rise && (bit_cnt == nvrs_pkg::BIT_LAST);
  wire ack_done  = scl_fall && (bit_cnt == nvrs_pkg::BIT_END);
  wire ack_phase = (slot == nvrs_pkg::BIT_ACK);

  function automatic logic [1:0] reg_index(input logic [7:0] a);
    reg_index = 2'(a - nvrs_pkg::REG_ZERO_ADDR);
  endfunction
  function automatic logic reg_valid(input logic [7:0] a);
    reg_valid = (a >= nvrs_pkg::REG_ZERO_ADDR) &&
                (a <= nvrs_pkg::REG_TWO_ADDR);
  endfunction

  wire [7:0] read_value = reg_valid(reg_addr) ?
                          setting[reg_index(reg_addr)] : 8'h00_00;
  wire tx_bit = (state == nvrs_pkg::NVRS_READ) && !ack_phase &&
                !read_value[3'(nvrs_pkg::BIT_LAST - slot)];

  // Bits are taken at the rising bus clock; slot follows at the falling
  // clock, so whatever the block drives changes only while it is low.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= nvrs_pkg::NVRS_IDLE;
      bit_cnt   <= 4'h0_0;
      slot      <= 4'h0_0;
      shift     <= 8'h00_00;
      reg_addr  <= 8'h00_00;
      data_byte <= 8'h00_00;
      is_read   <= 1'b0;
      ack_drive <= 1'b0;
      pend      <= 1'b0;
    end else if (start_c || stop_c) begin
      state     <= start_c ? nvrs_pkg::NVRS_DEVADDR : nvrs_pkg::NVRS_IDLE;
      bit_cnt   <= 4'h0_0;
      slot      <= 4'h0_0;
      ack_drive <= 1'b0;
      pend      <= 1'b0;
    end else if (byte_done) begin
      shift     <= rx_byte;
      bit_cnt   <= nvrs_pkg::BIT_ACK;
      case (state)
        nvrs_pkg::NVRS_DEVADDR: begin
          ack_drive <= addr_match && !busy;
          is_read   <= rx_byte[0];
        end
        nvrs_pkg::NVRS_REGADDR: begin
          ack_drive <= 1'b1;
          reg_addr  <= rx_byte;
        end
        nvrs_pkg::NVRS_DATA: begin
          ack_drive <= 1'b1;
          data_byte <= rx_byte;
          pend      <= reg_valid(reg_addr);
        end
        default: ack_drive <= 1'b0;
      endcase
    end else if (scl_rise) begin
      shift   <= rx_byte;
      bit_cnt <= (bit_cnt == nvrs_pkg::BIT_END) ? bit_cnt :
                 4'(bit_cnt + 4'h0_1);
    end else if (ack_done) begin
      bit_cnt   <= 4'h0_0;
      slot      <= 4'h0_0;
      ack_drive <= 1'b0;
      case (state)
        nvrs_pkg::NVRS_DEVADDR:
          state <= !ack_drive ? nvrs_pkg::NVRS_IGNORE :
                   is_read ? nvrs_pkg::NVRS_READ : nvrs_pkg::NVRS_REGADDR;
        nvrs_pkg::NVRS_REGADDR: state <= nvrs_pkg::NVRS_DATA;
        // Master acknowledge or not, the single-byte read ends here.
        nvrs_pkg::NVRS_READ: state <= nvrs_pkg::NVRS_IGNORE;
        default: state <= nvrs_pkg::NVRS_IGNORE;
      endcase
    end else if (scl_fall) begin
      slot <= bit_cnt;
    end
  end

  wire commit = stop_c && pend;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt <= 32'h0000_0000;
      busy     <= 1'b0;
    end else if (commit) begin
      busy_cnt <= 32'(WRITE_CYCLES);
      busy     <= 1'b1;
    end else if (busy_cnt != 32'h0000_0000) begin
      busy_cnt <= 32'(busy_cnt - 32'h0000_0001);
      busy     <= (busy_cnt != 32'h0000_0001);
    end
  end

  // Settings change at commit; the full byte is kept, high-Z bit included.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        setting[i] <= nvrs_pkg::SETTING_RESET;
      end
    end else if (commit) begin
      setting[reg_index(reg_addr)] <= data_byte;
    end
  end

  // Drive low only; the data line is never driven high.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_o                 <= 1'b0;
      sda_o                    <= 1'b0;
      nv_busy_o                <= 1'b0;
      resistor_zero_terminal_o <= nvrs_pkg::SETTING_RESET;
      resistor_one_terminal_o  <= nvrs_pkg::SETTING_RESET;
      resistor_two_terminal_o  <= nvrs_pkg::SETTING_RESET;
    end else begin
      sda_oe_o                 <= (ack_phase && ack_drive) || tx_bit;
      sda_o                    <= 1'b0;
      nv_busy_o                <= busy;
      resistor_zero_terminal_o <= setting[0];
      resistor_one_terminal_o  <= setting[1];
      resistor_two_terminal_o  <= setting[2];
    end
  end

  property p_reset_value;
    @(posedge mclk_i) $fell(rst_i) |->
      resistor_zero_terminal_o == nvrs_pkg::SETTING_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("setting not at factory value after reset");

  property p_commit_on_stop;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(busy) |-> $past(stop_c);
  endproperty
  a_commit_on_stop: assert property (p_commit_on_stop)
    else $error("commit started without stop");

  property p_no_ack_busy;
    @(posedge mclk_i) disable iff (rst_i)
      (busy && state == nvrs_pkg::NVRS_DEVADDR && ack_phase) |-> !ack_drive;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy)
    else $error("acknowledge during commit");

  property p_out_follows;
    @(posedge mclk_i) disable iff (rst_i)
      commit |-> ##2 (nv_busy_o && (resistor_zero_terminal_o == setting[0]));
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("outputs did not follow commit");

  property p_drive_low;
    @(posedge mclk_i) disable iff (rst_i) sda_oe_o |-> !sda_o;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data line driven high");

  property p_sda_steady;
    @(posedge mclk_i) disable iff (rst_i)
      (scl && scl_d) |-> $stable(sda_oe_o);
  endproperty
  a_sda_steady: assert property (p_sda_steady)
    else $error("data line changed while bus clock high");

  property p_ack_match;
    @(posedge mclk_i) disable iff (rst_i)
      (byte_done && !ack_phase && state == nvrs_pkg::NVRS_DEVADDR &&
       !addr_match) |=> !ack_drive;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("acknowledged foreign address");

  property p_read_value;
    @(posedge mclk_i) disable iff (rst_i)
      (state == nvrs_pkg::NVRS_READ && scl_rise && !ack_phase &&
       reg_valid(reg_addr))
      |-> sda_oe_o == !setting[reg_index(reg_addr)]
                              [3'(nvrs_pkg::BIT_LAST - slot)];
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("read value mismatch");

  property p_busy_len;
    @(posedge mclk_i) disable iff (rst_i)
      commit |=> busy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("commit cycle too short");

  c_write: cover property (@(posedge mclk_i) commit);
  c_read: cover property (@(posedge mclk_i) tx_bit);
  c_hiz: cover property (@(posedge mclk_i) resistor_two_terminal_o.hiz);
endmodule
`default_nettype wire

// File: testbench/nvrs_master.sv
/*
  Two-wire bus master model for the resistor setting bank.
  Assumes a pull-up on the data line: it is high unless pulled low.
*/
`default_nettype none
module nvrs_master (
  // Clock
  input  wire logic mclk_i,
  // Bus
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Data falls while the clock is high; also used as repeated start.
  task automatic start();
    sda_oe_o = 1'b0;
    hw(2);
    scl_o = 1'b1;
    hw(3);
    sda_oe_o = 1'b1;
    hw(3);
    scl_o = 1'b0;
    hw(2);
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    hw(3);
    scl_o = 1'b1;
    hw(3);
    sda_oe_o = 1'b0;
    hw(3);
  endtask
  // One 80 ns bit, clock high for 40 ns of it; data only changes while the clock is low.
  task automatic xfer(input logic b, output logic r);
    sda_oe_o = !b;
    hw(3);
    scl_o = 1'b1;
    hw(3);
    r = sda_i;
    hw(2);
    scl_o = 1'b0;
    hw(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = !r;
  endtask
  // The read ends with a not-acknowledge.
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(1'b1, r);
  endtask
endmodule
`default_nettype wire

// File: testbench/nvrs_top_tb.sv
/*
  Self-checking bench for the resistor setting bank.
  Assumes the master model in nvrs_master and a pulled-up data line.
*/
`default_nettype none
module nvrs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    mclk = 1'b0;
  logic                    rst  = 1'b1;
  logic                    scl;
  logic                    m_oe;
  logic                    d_oe;
  logic                    d_o;
  logic                    busy;
  logic                    a;
  logic [7:0]              d;
  logic [2:0]              pins = 3'h5;
  logic [7:0]              ev [3] = '{8'h00, 8'h80, 8'hc5};
  nvrs_pkg::nvrs_setting_t t0, t1, t2;
  int                      miscompares = 0;
  int                      comparisons = 0;
  wire                     sda = !(m_oe | d_oe);
  always #4 mclk = ~mclk;
  nvrs_top #(.WRITE_CYCLES(300)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
    .sda_oe_o(d_oe), .address_select_pin_0_i(pins[0]),
    .address_select_pin_1_i(pins[1]), .address_select_pin_2_i(pins[2]),
    .resistor_zero_terminal_o(t0), .resistor_one_terminal_o(t1),
    .resistor_two_terminal_o(t2), .nv_busy_o(busy));
  nvrs_master i_mst (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(m_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {nvrs_pkg::DEV_ADDR_FIXED, pins, rw};
  endfunction
  // The device only ever pulls the data line low.
  always @(negedge mclk) if (d_oe && d_o !== 1'b0) chk(d_o, 8'h00);
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    i_mst.start();
    i_mst.wbyte(dev(1'b0), a);
    chk({7'h00, a}, 8'h01);
    i_mst.wbyte(r, a);
    chk({7'h00, a}, 8'h01);
    i_mst.wbyte(v, a);
    chk({7'h00, a}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    i_mst.stop();
    repeat (6) @(negedge mclk);
    chk({7'h00, busy}, 8'h01);
    i_mst.start();
    i_mst.wbyte(dev(1'b0), a);
    chk({7'h00, a}, 8'h00);
    i_mst.stop();
    wait_idle();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] v);
    i_mst.start();
    i_mst.wbyte(dev(1'b0), a);
    i_mst.wbyte(r, a);
    i_mst.start();
    i_mst.wbyte(dev(1'b1), a);
    chk({7'h00, a}, 8'h01);
    i_mst.rbyte(v);
    i_mst.stop();
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk(t0, 8'h7f);
    chk(t1, 8'h7f);
    chk(t2, 8'h7f);
    rd(8'hf8, d);
    chk(d, 8'h7f);
    wr(8'hf8, 8'h00);
    chk(t0, 8'h00);
    wr(8'hf9, 8'h80);
    chk(t1, 8'h80);
    wr(8'hfa, 8'hc5);
    chk(t2, 8'hc5);
    chk(t0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd(8'hf8 + 8'(i), d);
      chk(d, ev[i]);
    end
    wr(8'hf8, 8'h7f);
    chk(t0, 8'h7f);
    rd(8'hfb, d);
    chk(d, 8'h00);
    pins = 3'h2;
    i_mst.start();
    i_mst.wbyte({nvrs_pkg::DEV_ADDR_FIXED, 3'h5, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    i_mst.stop();
    rd(8'hf9, d);
    chk(d, 8'h80);
    give_verdict();
  end
endmodule
`default_nettype wire
